// ==== core/muc_mac_upper_control.sv ====
// module: upper control fields of the mac control word and their effects
`timescale 1ns/10ps
`default_nettype none
// Function
// - bits 31 to 19 of the control word read zero; writes there ignored.
// - external select takes duplex and gigabit mode from the external pins.
// - external select bit is driven continuously onto its own output.
// - gigabit force keeps gigabit mode when the slow-rate transmit clock stopped.
// - two interface-control bits drive general-purpose outputs only.
// - block bit clear: descriptor offset/length word written back normally.
// - block bit set: every write to descriptor word 2 (word field value 2) is suppressed.
// - ownership value clear: descriptor ownership flag written as zero.
// - ownership value set: descriptor ownership flag written as one.
// - fifo flow enable clear: no outgoing pause frames in full duplex.
// - fifo flow enable set and full duplex: pause sent when flow triggered.
// - idle command requests idle; reached idle shows in status word.
// - short-gap enable set: short gap while input asserted; clear: never.
// - priority type clear: round-robin among transmit channels with pending work.
// - priority type set: fixed priority, channel 7 highest.
// - gigabit selection clear runs 10/100 unless gigabit force applies; set runs gigabit, full duplex only.
// - gigabit mode forces full duplex whatever the duplex selection.
module muc_mac_upper_control #(
    parameter int STOP_CYCLES = muc_pkg::MUC_STOP_CYCLES,
    parameter int NUM_CH = 8
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // register port
    input wire logic [muc_pkg::MUC_AW-1:0] addr_i,
    input wire logic [31:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rd_data_o,
    // mode pins
    input wire logic external_duplex_in_i,
    input wire logic external_gigabit_in_i,
    input wire logic slow_rate_tx_clock_in_i,
    output logic external_select_o,
    output logic gig_mode_o,
    output logic full_duplex_o,
    output logic gpio_a_o,
    output logic gpio_b_o,
    // receive descriptor write-back
    input wire muc_pkg::muc_desc_wr_t desc_i,
    output muc_pkg::muc_desc_wr_t desc_o,
    // flow control, gap and idle
    input wire logic rx_fifo_flow_trig_i,
    output logic pause_req_o,
    input wire logic short_gap_i,
    output logic short_gap_o,
    input wire logic tx_busy_i,
    input wire logic rx_busy_i,
    output logic idle_o,
    // transmit channel arbitration
    input wire logic [NUM_CH-1:0] tx_pend_i,
    input wire logic tx_arb_req_i,
    output logic [$clog2(NUM_CH)-1:0] tx_grant_o,
    output logic tx_grant_vld_o
);
    import muc_pkg::*;

    localparam int CW = $clog2(NUM_CH);
    localparam int SW = $clog2(STOP_CYCLES + 1);

    // ****************************************
    // channel pick functions
    // ****************************************
    function automatic logic [CW-1:0] prio_pick(input logic [NUM_CH-1:0] p);
        logic [CW-1:0] r;
        r = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (p[i]) begin
                r = CW'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [CW-1:0] rr_pick(input logic [NUM_CH-1:0] p,
                                              input logic [CW-1:0] last);
        logic [CW-1:0] r;
        logic [CW-1:0] idx;
        r = last;
        for (int k = NUM_CH; k >= 1; k--) begin
            idx = CW'((int'(last) + k) % NUM_CH);
            if (p[idx]) begin
                r = idx;
            end
        end
        return r;
    endfunction

    // ****************************************
    // register file
    // ****************************************
    logic [31:0] ctl;
    logic [31:0] next_ctl;
    logic [31:0] next_rd_data;
    logic clk_stop;
    muc_idle_st_t st;

    always_comb begin
        next_ctl = ctl;
        if (wr_i && addr_i == MUC_OFF_CTL) begin
            next_ctl = wr_data_i & MUC_CTL_WMASK;
        end
        next_rd_data = 32'h00000000;
        if (rd_i && addr_i == MUC_OFF_CTL) begin
            next_rd_data = ctl;
        end else if (rd_i && addr_i == MUC_OFF_STS) begin
            next_rd_data[STS_IDLE] = (st == ST_IDLE);
            next_rd_data[STS_CLK_STOP] = clk_stop;
            next_rd_data[STS_GIG] = gig_mode_o;
            next_rd_data[STS_FDX] = full_duplex_o;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ctl <= MUC_CTL_RESET;
            rd_data_o <= 32'h00000000;
        end else begin
            ctl <= next_ctl;
            rd_data_o <= next_rd_data;
        end
    end

    assign external_select_o = ctl[CTL_EXT_SEL];
    assign gpio_a_o = ctl[CTL_GPIO_A];
    assign gpio_b_o = ctl[CTL_GPIO_B];

    // ****************************************
    // slow-rate transmit clock stop detector
    // ****************************************
    logic tx_clk_prev;
    logic [SW-1:0] stop_cnt;
    logic next_clk_stop;
    logic [SW-1:0] next_stop_cnt;

    always_comb begin
        next_stop_cnt = stop_cnt;
        if (slow_rate_tx_clock_in_i != tx_clk_prev) begin
            next_stop_cnt = '0;
        end else if (stop_cnt != SW'(STOP_CYCLES)) begin
            next_stop_cnt = stop_cnt + SW'(1);
        end
        next_clk_stop = (next_stop_cnt == SW'(STOP_CYCLES));
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            tx_clk_prev <= 1'b0;
            stop_cnt <= '0;
            clk_stop <= 1'b0;
        end else begin
            tx_clk_prev <= slow_rate_tx_clock_in_i;
            stop_cnt <= next_stop_cnt;
            clk_stop <= next_clk_stop;
        end
    end

    // ****************************************
    // effective modes
    // ****************************************
    logic sel_gig;
    logic sel_fdx;
    logic next_gig;
    logic next_fdx;
    logic next_pause;
    logic next_gap;

    always_comb begin
        sel_gig = ctl[CTL_EXT_SEL] ? external_gigabit_in_i : ctl[CTL_GIG];
        sel_fdx = ctl[CTL_EXT_SEL] ? external_duplex_in_i : ctl[CTL_FDX];
        next_gig = sel_gig | (ctl[CTL_GIG_FORCE] & clk_stop);
        next_fdx = sel_fdx | next_gig;
        next_pause = ctl[CTL_FIFO_FLOW] & next_fdx & rx_fifo_flow_trig_i;
        next_gap = ctl[CTL_SHORT_GAP] & short_gap_i;
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            gig_mode_o <= 1'b0;
            full_duplex_o <= 1'b0;
            pause_req_o <= 1'b0;
            short_gap_o <= 1'b0;
        end else begin
            gig_mode_o <= next_gig;
            full_duplex_o <= next_fdx;
            pause_req_o <= next_pause;
            short_gap_o <= next_gap;
        end
    end

    // ****************************************
    // receive descriptor write-back
    // ****************************************
    muc_desc_wr_t next_desc;

    always_comb begin
        next_desc = desc_i;
        if (ctl[CTL_OFFLEN_BLK] && desc_i.word == DESC_WORD_OFFLEN) begin
            next_desc.vld = 1'b0;
        end
        if (desc_i.own) begin
            next_desc.data[DESC_OWN_BIT] = ctl[CTL_RX_OWN];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            desc_o <= '0;
        end else begin
            desc_o <= next_desc;
        end
    end

    // ****************************************
    // idle command sequence
    // ****************************************
    muc_idle_st_t next_st;

    always_comb begin
        case (st)
            ST_RUN: begin
                next_st = ctl[CTL_CMD_IDLE] ? ST_DRAIN : ST_RUN;
            end
            ST_DRAIN: begin
                if (!ctl[CTL_CMD_IDLE]) begin
                    next_st = ST_RUN;
                end else if (!tx_busy_i && !rx_busy_i) begin
                    next_st = ST_IDLE;
                end else begin
                    next_st = ST_DRAIN;
                end
            end
            ST_IDLE: begin
                next_st = ctl[CTL_CMD_IDLE] ? ST_IDLE : ST_RUN;
            end
            default: begin
                next_st = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st <= ST_RUN;
        end else begin
            st <= next_st;
        end
    end

    assign idle_o = (st == ST_IDLE);

    // ****************************************
    // transmit channel arbitration
    // ****************************************
    logic [CW-1:0] last_ch;
    logic [CW-1:0] next_last_ch;
    logic next_grant_vld;

    always_comb begin
        next_last_ch = last_ch;
        next_grant_vld = 1'b0;
        if (tx_arb_req_i && |tx_pend_i && st == ST_RUN) begin
            next_grant_vld = 1'b1;
            if (ctl[CTL_PTYPE]) begin
                next_last_ch = prio_pick(tx_pend_i);
            end else begin
                next_last_ch = rr_pick(tx_pend_i, last_ch);
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            last_ch <= CW'(NUM_CH - 1);
            tx_grant_vld_o <= 1'b0;
        end else begin
            last_ch <= next_last_ch;
            tx_grant_vld_o <= next_grant_vld;
        end
    end

    assign tx_grant_o = last_ch;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    logic wr_ctl;
    assign wr_ctl = wr_i && addr_i == MUC_OFF_CTL;

    chk_resv_zero: assert property (rd_i |=> rd_data_o[31:19] == 13'h0000)
        else $error("reserved control bits read nonzero");
    chk_ext_pins: assert property (ctl[CTL_EXT_SEL] && external_gigabit_in_i
        |=> gig_mode_o && full_duplex_o)
        else $error("external gigabit pin not followed");
    chk_ext_out: assert property (wr_ctl |=> external_select_o == $past(wr_data_i[CTL_EXT_SEL]))
        else $error("external select output wrong");
    chk_gig_force: assert property (ctl[CTL_GIG_FORCE] && clk_stop |=> gig_mode_o)
        else $error("forced gigabit mode not held");
    chk_gpio_out: assert property (wr_ctl |=> gpio_a_o == $past(wr_data_i[15])
        && gpio_b_o == $past(wr_data_i[16]))
        else $error("interface control outputs wrong");
    chk_offlen_pass: assert property (desc_i.vld && !ctl[CTL_OFFLEN_BLK] |=> desc_o.vld)
        else $error("descriptor write dropped");
    chk_offlen_blk: assert property (desc_i.vld && desc_i.word == DESC_WORD_OFFLEN
        && ctl[CTL_OFFLEN_BLK] |=> !desc_o.vld)
        else $error("offset length write not blocked");
    chk_own_value: assert property (desc_i.vld && desc_i.own
        |=> desc_o.data[DESC_OWN_BIT] == $past(ctl[CTL_RX_OWN]))
        else $error("ownership flag value wrong");
    chk_pause_off: assert property (!ctl[CTL_FIFO_FLOW] |=> !pause_req_o)
        else $error("pause sent while disabled");
    chk_pause_on: assert property (ctl[CTL_FIFO_FLOW] && rx_fifo_flow_trig_i && !ctl[CTL_EXT_SEL]
        && (ctl[CTL_GIG] || ctl[CTL_FDX]) |=> pause_req_o)
        else $error("pause not sent");
    chk_idle_drop: assert property (!ctl[CTL_CMD_IDLE] |=> !idle_o)
        else $error("idle shown without command");
    chk_idle_reach: assert property ((ctl[CTL_CMD_IDLE] && !tx_busy_i && !rx_busy_i)
        [*3] |-> idle_o)
        else $error("idle not reached");
    chk_gap_off: assert property (!ctl[CTL_SHORT_GAP] |=> !short_gap_o)
        else $error("short gap used while disabled");
    chk_rr_rotate: assert property (tx_grant_vld_o && !$past(ctl[CTL_PTYPE])
        && ($past(tx_pend_i) & ~((NUM_CH)'(1) << $past(last_ch))) != '0
        |-> tx_grant_o != $past(tx_grant_o))
        else $error("round robin repeated a channel");
    chk_fixed_top: assert property (tx_arb_req_i && ctl[CTL_PTYPE] && tx_pend_i[NUM_CH-1]
        && st == ST_RUN |=> tx_grant_vld_o && tx_grant_o == CW'(NUM_CH - 1))
        else $error("fixed priority top channel not chosen");
    chk_gig_fdx: assert property (gig_mode_o |-> full_duplex_o)
        else $error("gigabit without full duplex");
    chk_ctl_hold: assert property (!wr_ctl |=> $stable(ctl))
        else $error("control word changed without write");

endmodule // muc_mac_upper_control
`default_nettype wire

// ==== core/muc_pkg.sv ====
// package: constants and carriers for the mac upper control block
package muc_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam int MUC_AW = 8;
    localparam logic [MUC_AW-1:0] MUC_OFF_CTL = 8'h00;
    localparam logic [MUC_AW-1:0] MUC_OFF_STS = 8'h04;
    localparam logic [31:0] MUC_CTL_RESET = 32'h00000000;
    localparam logic [31:0] MUC_CTL_WMASK = 32'h0007FE81;
    // ****************************************
    // control word fields
    // ****************************************
    localparam int CTL_EXT_SEL = 18;
    localparam int CTL_GIG_FORCE = 17;
    localparam int CTL_GPIO_B = 16;
    localparam int CTL_GPIO_A = 15;
    localparam int CTL_OFFLEN_BLK = 14;
    localparam int CTL_RX_OWN = 13;
    localparam int CTL_FIFO_FLOW = 12;
    localparam int CTL_CMD_IDLE = 11;
    localparam int CTL_SHORT_GAP = 10;
    localparam int CTL_PTYPE = 9;
    localparam int CTL_GIG = 7;
    localparam int CTL_FDX = 0;
    // ****************************************
    // status word fields
    // ****************************************
    localparam int STS_IDLE = 0;
    localparam int STS_CLK_STOP = 1;
    localparam int STS_GIG = 2;
    localparam int STS_FDX = 3;
    // ****************************************
    // descriptor write-back and timing
    // ****************************************
    localparam logic [1:0] DESC_WORD_OFFLEN = 2'h2;
    localparam int DESC_OWN_BIT = 29;
    localparam int MUC_STOP_CYCLES = 64;
    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic vld;
        logic [1:0] word;
        logic own;
        logic [31:0] data;
    } muc_desc_wr_t;
    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_DRAIN = 3'b010,
        ST_IDLE = 3'b100
    } muc_idle_st_t;
endpackage

// ==== verification/muc_mac_upper_control_bench.sv ====
// testbench: self-checking scenarios for the mac upper control block
`timescale 1ns/10ps
`default_nettype none
module muc_mac_upper_control_bench;
    import muc_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    logic sys_clk_i, rst_i, wr_i, rd_i, ext_sel, gig, fdx, gpa, gpb;
    logic [MUC_AW-1:0] addr_i;
    logic [31:0] wr_data_i, rd_data_o, rdv;
    logic ext_dup, external_gigabit_in, slow_clk, slow_run, trig, pause, sg_i, sg_o;
    logic tx_busy, rx_busy, idle, arb_req, gvld;
    logic [7:0] pend;
    logic [2:0] grant;
    muc_desc_wr_t desc_i, desc_o;
    int n_fail, num_checks;
    muc_mac_upper_control #(.STOP_CYCLES(4), .NUM_CH(8)) uut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
        .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
        .external_duplex_in_i(ext_dup), .external_gigabit_in_i(external_gigabit_in),
        .slow_rate_tx_clock_in_i(slow_clk), .external_select_o(ext_sel),
        .gig_mode_o(gig), .full_duplex_o(fdx), .gpio_a_o(gpa), .gpio_b_o(gpb),
        .desc_i(desc_i), .desc_o(desc_o), .rx_fifo_flow_trig_i(trig),
        .pause_req_o(pause), .short_gap_i(sg_i), .short_gap_o(sg_o),
        .tx_busy_i(tx_busy), .rx_busy_i(rx_busy), .idle_o(idle),
        .tx_pend_i(pend), .tx_arb_req_i(arb_req), .tx_grant_o(grant),
        .tx_grant_vld_o(gvld)
    );
    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        if (slow_run) begin
            slow_clk <= ~slow_clk;
        end
    end
    // ****************************************
    // helpers
    // ****************************************
    task automatic give_verdict();
        if (n_fail == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [MUC_AW-1:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wr_data_i <= d;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [MUC_AW-1:0] a);
        @(posedge sys_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 rdv = rd_data_o;
    endtask
    task automatic settle();
        repeat (3) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic wctl(input logic [31:0] d);
        wr(MUC_OFF_CTL, d);
        settle();
    endtask
    task automatic arb(input logic [7:0] p);
        @(posedge sys_clk_i);
        pend <= p;
        arb_req <= 1'b1;
        @(posedge sys_clk_i);
        arb_req <= 1'b0;
        #1;
    endtask
    task automatic desc(input logic [1:0] w, input logic o);
        @(posedge sys_clk_i);
        desc_i <= '{vld: 1'b1, word: w, own: o, data: 32'hFFFFFFFF};
        @(posedge sys_clk_i);
        desc_i <= '{vld: 1'b0, word: 2'h0, own: 1'b0, data: 32'h00000000};
        #1;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs();
        check({grant, gvld, idle, pause, gig, fdx}, {3'h7, 5'h00});
        wctl(32'hFFFFFFFF);
        rd(MUC_OFF_CTL);
        check(rdv, 32'h0007FE81);
        wr(8'h08, 32'h00000000);
        rd(MUC_OFF_CTL);
        check(rdv, 32'h0007FE81);
        settle();
        check(rd_data_o, 32'h00000000);
        rd(8'h0C);
        check(rdv, 32'h00000000);
        wctl(32'h00048000);
        check({ext_sel, gpb, gpa}, 3'b101);
        wctl(32'h00010000);
        check({ext_sel, gpb, gpa, gig, fdx}, 5'b01000);
    endtask
    task automatic t_ext();
        wctl(32'h00000001);
        check({gig, fdx}, 2'b01);
        wctl(32'h00000080);
        check({gig, fdx}, 2'b11);
        @(posedge sys_clk_i);
        external_gigabit_in <= 1'b0;
        ext_dup <= 1'b0;
        wctl(32'h00040081);
        check({gig, fdx}, 2'b00);
        @(posedge sys_clk_i);
        ext_dup <= 1'b1;
        settle();
        check({gig, fdx}, 2'b01);
        @(posedge sys_clk_i);
        ext_dup <= 1'b0;
        external_gigabit_in <= 1'b1;
        settle();
        check({gig, fdx}, 2'b11);
        rd(MUC_OFF_STS);
        check(rdv[3:2], 2'b11);
        @(posedge sys_clk_i);
        external_gigabit_in <= 1'b0;
    endtask
    task automatic t_force();
        wctl(32'h00020000);
        repeat (10) @(posedge sys_clk_i);
        #1 check({gig, fdx}, 2'b00);
        slow_run <= 1'b0;
        repeat (10) @(posedge sys_clk_i);
        #1 check({gig, fdx}, 2'b11);
        rd(MUC_OFF_STS);
        check(rdv[1], 1'b1);
        wctl(32'h00000000);
        check(gig, 1'b0);
        slow_run <= 1'b1;
    endtask
    task automatic t_desc();
        wctl(32'h00000000);
        desc(2'h2, 1'b1);
        check({desc_o.vld, desc_o.word, desc_o.data[29]}, 4'b1100);
        check(desc_o.data, 32'hDFFFFFFF);
        wctl(32'h00006000);
        desc(2'h2, 1'b0);
        check(desc_o.vld, 1'b0);
        desc(2'h1, 1'b1);
        check({desc_o.vld, desc_o.data}, {1'b1, 32'hFFFFFFFF});
    endtask
    task automatic t_pause();
        @(posedge sys_clk_i);
        trig <= 1'b1;
        wctl(32'h00001000);
        check(pause, 1'b0);
        wctl(32'h00001001);
        check(pause, 1'b1);
        wctl(32'h00000001);
        check(pause, 1'b0);
        @(posedge sys_clk_i);
        trig <= 1'b0;
    endtask
    task automatic t_gap();
        @(posedge sys_clk_i);
        sg_i <= 1'b1;
        settle();
        check(sg_o, 1'b0);
        wctl(32'h00000400);
        check(sg_o, 1'b1);
        @(posedge sys_clk_i);
        sg_i <= 1'b0;
        settle();
        check(sg_o, 1'b0);
    endtask
    task automatic t_arb();
        wctl(32'h00000000);
        arb(8'hFF);
        check({gvld, grant}, 4'h8);
        arb(8'hFF);
        check({gvld, grant}, 4'h9);
        arb(8'h81);
        check({gvld, grant}, 4'hF);
        wctl(32'h00000200);
        arb(8'h15);
        check({gvld, grant}, 4'hC);
        arb(8'h81);
        check({gvld, grant}, 4'hF);
        arb(8'h00);
        check(gvld, 1'b0);
    endtask
    task automatic t_idle();
        int k;
        @(posedge sys_clk_i);
        tx_busy <= 1'b1;
        rx_busy <= 1'b1;
        wctl(32'h00000800);
        check(idle, 1'b0);
        @(posedge sys_clk_i);
        tx_busy <= 1'b0;
        settle();
        check(idle, 1'b0);
        @(posedge sys_clk_i);
        rx_busy <= 1'b0;
        k = 0;
        while (idle !== 1'b1 && k < 20) begin
            @(posedge sys_clk_i);
            #1 k++;
        end
        if (k == 20) begin
            n_fail++;
            $display("MISMATCH t=%0t idle timeout got=%h exp=%h", $time, idle, 1'b1);
            give_verdict();
        end
        rd(MUC_OFF_STS);
        check(rdv[0], 1'b1);
        arb(8'hFF);
        check(gvld, 1'b0);
        wctl(32'h00000000);
        check(idle, 1'b0);
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        n_fail = 0;
        num_checks = 0;
        rst_i = 1'b1;
        {wr_i, rd_i, ext_dup, external_gigabit_in, slow_clk, trig, sg_i, tx_busy, rx_busy} = '0;
        {arb_req, addr_i, wr_data_i, pend} = '0;
        slow_run = 1'b1;
        desc_i = '0;
        repeat (3) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(posedge sys_clk_i);
        #1;
        t_regs();
        t_ext();
        t_force();
        t_desc();
        t_pause();
        t_gap();
        t_arb();
        t_idle();
        give_verdict();
    end
endmodule // muc_mac_upper_control_bench
`default_nettype wire
